// file: scadc_top.sv
/*
 * Converter boundary-scan cells: shift, update and drive stages on TCK that
 * drive the converter's control lines and observe its comparator, plus the
 * power-on dummy-conversion tracker on CLK.
 * Assumes a test controller on TCK that strobes capture, shift and update in
 * the usual order and holds SCAN_EXTEST while the cells own the converter.
 */
module scadc_top
    import scadc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic TCK,
    input wire logic SCAN_TDI,
    input wire logic SCAN_CAPTURE,
    input wire logic SCAN_SHIFT,
    input wire logic SCAN_UPDATE,
    input wire logic SCAN_EXTEST,
    input wire logic COMP_IN,
    output logic SCAN_TDO,
    output logic [CHAN_W-1:0] POS_CHANNEL_SELECT,
    output logic [NEG_W-1:0] NEG_INPUT_SELECT,
    output logic AMP_PASSGATE_ENABLE,
    output logic COMPARATOR_PRECHARGE_N,
    output logic SWITCHCAP_TEST_ROUTE,
    output logic SETTLE_ASSIST,
    output logic SUPPLY_REF_SELECT,
    output logic AMP_POWER_ON,
    output logic CONVERTER_POWER_ON,
    output logic [DAC_W-1:0] DAC_WORD,
    output logic SAMPLE_HOLD,
    output logic BANDGAP_NEG_SELECT,
    output logic GROUND_NEG_SELECT,
    output logic BYPASS_SELECT,
    output logic BANDGAP_AREF_SELECT,
    output logic AMP_PATH_ENABLE,
    output logic AMP_CLOCK,
    output logic SOURCE_CONFLICT,
    output logic CHANNEL_SELECT_ERR,
    output logic SAMPLE_DAC_ERR,
    output logic CONVERTER_BUSY,
    output logic CONVERTER_READY
);

    // Scan-side state, all on TCK
    typedef struct packed {
        logic [CHAIN_LEN-1:0] shift; // Shift stage
        logic [CHAIN_LEN-1:0] upd; // Update stage, loaded by the controller
        logic [CHAIN_LEN-1:0] drv; // Lines actually driven into the converter
        logic tdo; // Serial output
        logic conflict; // More than one negative source chosen
        logic chan_err; // Positive select not one-hot
        logic samp_err; // DAC off midpoint while sampling
    } scadc_tck_s;

    // Power-on tracker state, on CLK
    typedef struct packed {
        scadc_conv_e state; // Off, dummy conversion, ready
        logic [CNT_W-1:0] cmp_cnt; // Dummy comparisons left
        logic [CNT_W-1:0] wait_cnt; // Settle cycles left
        logic power_d; // Power level one cycle ago
        logic busy; // Dummy conversion running
        logic ready; // Signals may be used
    } scadc_clk_s;

    scadc_tck_s tck_ff;
    scadc_tck_s nxt_tck;
    scadc_clk_s clk_ff;
    scadc_clk_s nxt_clk;

    logic comp_sync; // Comparator after two TCK flops
    logic power_sync; // Converter power after two CLK flops
    logic comp_seen; // Value captured into the result cell
    logic [1:0] neg_sources; // Count of negative S&H sources

    // The comparator is an asynchronous analog output
    scadc_sync #(.W(1)) u_comp_sync (
        .clk(TCK),
        .rst_n(RST_N),
        .ce(1'b1),
        .d(COMP_IN),
        .q(comp_sync)
    );

    // Power level crosses to CLK; it changes only on update or a SCAN_EXTEST change, so a level is enough
    scadc_sync #(.W(1)) u_power_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .d(tck_ff.drv[POS_CONV_ON]),
        .q(power_sync)
    );

    // Unpowered converter reads as zero on its result cell
    assign comp_seen = comp_sync & tck_ff.drv[POS_CONV_ON];

    // Scan stages; outside external test the converter gets the idle pattern
    always_comb begin
        nxt_tck = tck_ff;
        neg_sources = 2'h0;
        if (SCAN_CAPTURE) begin
            // Control cells read back what they drive, result cell samples comparator
            nxt_tck.shift = tck_ff.drv;
            nxt_tck.shift[POS_COMP] = comp_seen;
        end else if (SCAN_SHIFT) begin
            // Bit 0 leaves first, TDI enters at the top
            nxt_tck.shift = {SCAN_TDI, tck_ff.shift[CHAIN_LEN-1:1]};
        end
        if (SCAN_UPDATE) begin
            nxt_tck.upd = tck_ff.shift;
        end
        // Idle pattern keeps the analog part quiet when the cells do not own it
        nxt_tck.drv = SCAN_EXTEST ? nxt_tck.upd : CELLS_IDLE;
        nxt_tck.tdo = nxt_tck.shift[0];
        // Count negative S&H sources: channel pin, bandgap, ground
        neg_sources = 2'({1'b0, |nxt_tck.drv[POS_CHAN_HI:POS_CHAN_LO]})
            + 2'({1'b0, nxt_tck.drv[POS_BG_NEG]}) + 2'({1'b0, nxt_tck.drv[POS_GND_NEG]});
        // Reported only; the cells still drive what was loaded
        nxt_tck.conflict = (neg_sources > 2'h1);
        nxt_tck.chan_err = !$onehot(nxt_tck.drv[POS_CHAN_HI:POS_CHAN_LO]);
        nxt_tck.samp_err = !nxt_tck.drv[POS_HOLD]
            && (nxt_tck.drv[POS_DAC_HI:POS_DAC_LO] != DAC_MIDPOINT);
    end

    // Scan register; reset loads idle so the converter never sees junk
    always_ff @(posedge TCK or negedge RST_N) begin
        if (!RST_N) begin
            tck_ff <= '{shift: CELLS_IDLE, upd: CELLS_IDLE, drv: CELLS_IDLE, tdo: 1'b0,
                conflict: 1'b0, chan_err: 1'b0, samp_err: 1'b0};
        end else begin
            tck_ff <= nxt_tck;
        end
    end

    // Dummy conversion after power-on, with the settle wait running alongside
    always_comb begin
        nxt_clk = clk_ff;
        nxt_clk.power_d = power_sync;
        unique case (clk_ff.state)
            CV_OFF: begin
                // Rising power starts the ten comparisons and the wait together
                if (power_sync && !clk_ff.power_d) begin
                    nxt_clk.state = CV_DUMMY;
                    nxt_clk.cmp_cnt = CNT_W'(DUMMY_CMPS);
                    nxt_clk.wait_cnt = CNT_W'(SETTLE_CYC);
                end
            end
            CV_DUMMY: begin
                // Both counts must run out; the longer one decides
                if (clk_ff.cmp_cnt == '0 && clk_ff.wait_cnt == '0) begin
                    nxt_clk.state = CV_READY;
                end
                if (clk_ff.cmp_cnt != '0) begin
                    nxt_clk.cmp_cnt = clk_ff.cmp_cnt - CNT_W'(1);
                end
                if (clk_ff.wait_cnt != '0) begin
                    nxt_clk.wait_cnt = clk_ff.wait_cnt - CNT_W'(1);
                end
            end
            CV_READY: begin
                // Stay until power goes away
            end
        endcase
        // Power-off aborts at any point
        if (!power_sync) begin
            nxt_clk.state = CV_OFF;
        end
        nxt_clk.busy = (nxt_clk.state == CV_DUMMY);
        nxt_clk.ready = (nxt_clk.state == CV_READY);
    end

    // Tracker register, frozen while CE is low
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_ff <= '{state: CV_OFF, cmp_cnt: '0, wait_cnt: '0, power_d: 1'b0, busy: 1'b0, ready: 1'b0};
        end else if (CE) begin
            clk_ff <= nxt_clk;
        end
    end

    // Converter lines straight from the drive register
    assign SCAN_TDO = tck_ff.tdo;
    assign POS_CHANNEL_SELECT = tck_ff.drv[POS_CHAN_HI:POS_CHAN_LO];
    assign NEG_INPUT_SELECT = tck_ff.drv[POS_NEG_HI:POS_NEG_LO];
    assign AMP_PASSGATE_ENABLE = tck_ff.drv[POS_PASSGATE];
    assign COMPARATOR_PRECHARGE_N = tck_ff.drv[POS_COMPARATOR_PRECHARGE_N_N];
    assign SWITCHCAP_TEST_ROUTE = tck_ff.drv[POS_SWITCHCAP_TEST_ROUTE];
    assign SETTLE_ASSIST = tck_ff.drv[POS_SETTLE];
    assign SUPPLY_REF_SELECT = tck_ff.drv[POS_SUPPLY_REF];
    assign AMP_POWER_ON = tck_ff.drv[POS_AMP_ON];
    assign CONVERTER_POWER_ON = tck_ff.drv[POS_CONV_ON];
    assign DAC_WORD = tck_ff.drv[POS_DAC_HI:POS_DAC_LO];
    assign SAMPLE_HOLD = tck_ff.drv[POS_HOLD];
    assign BANDGAP_NEG_SELECT = tck_ff.drv[POS_BG_NEG];
    assign GROUND_NEG_SELECT = tck_ff.drv[POS_GND_NEG];
    assign BYPASS_SELECT = tck_ff.drv[POS_BYPASS];
    assign BANDGAP_AREF_SELECT = tck_ff.drv[POS_BG_AREF];
    assign AMP_PATH_ENABLE = tck_ff.drv[POS_AMP_PATH];
    assign AMP_CLOCK = tck_ff.drv[POS_AMP_CLK];
    assign SOURCE_CONFLICT = tck_ff.conflict;
    assign CHANNEL_SELECT_ERR = tck_ff.chan_err;
    assign SAMPLE_DAC_ERR = tck_ff.samp_err;
    assign CONVERTER_BUSY = clk_ff.busy;
    assign CONVERTER_READY = clk_ff.ready;

    // Two TCK edges outside external test bring the idle pattern out
    sequence idle_two_s;
        !SCAN_EXTEST ##1 !SCAN_EXTEST;
    endsequence

    neg_idle_a: assert property (@(posedge TCK) disable iff (!RST_N)
        idle_two_s |-> NEG_INPUT_SELECT == NEG_IDLE)
        else $error("negative select not idle");
    pass_idle_a: assert property (@(posedge TCK) disable iff (!RST_N)
        idle_two_s |-> AMP_PASSGATE_ENABLE && !AMP_POWER_ON)
        else $error("pass-gate not idle");
    comparator_precharge_n_idle_a: assert property (@(posedge TCK) disable iff (!RST_N)
        idle_two_s |-> COMPARATOR_PRECHARGE_N)
        else $error("precharge asserted while idle");
    switchcap_test_route_idle_a: assert property (@(posedge TCK) disable iff (!RST_N)
        idle_two_s |-> !SWITCHCAP_TEST_ROUTE && !SETTLE_ASSIST)
        else $error("switch-cap route not idle");
    vccref_idle_a: assert property (@(posedge TCK) disable iff (!RST_N)
        idle_two_s |-> !SUPPLY_REF_SELECT)
        else $error("supply reference not idle");
    hold_idle_a: assert property (@(posedge TCK) disable iff (!RST_N)
        idle_two_s |-> SAMPLE_HOLD && !CONVERTER_POWER_ON)
        else $error("hold or power not idle");
    dac_idle_a: assert property (@(posedge TCK) disable iff (!RST_N)
        idle_two_s |-> DAC_WORD == DAC_MIDPOINT)
        else $error("DAC word not idle");

    // Update under external test reaches the lines on the update edge itself
    update_drive_a: assert property (@(posedge TCK) disable iff (!RST_N)
        SCAN_UPDATE && SCAN_EXTEST |=> SAMPLE_HOLD == $past(tck_ff.shift[POS_HOLD]))
        else $error("update did not reach hold line");
    comp_off_a: assert property (@(posedge TCK) disable iff (!RST_N)
        SCAN_CAPTURE && !CONVERTER_POWER_ON |=> !tck_ff.shift[POS_COMP])
        else $error("result cell nonzero while unpowered");
    // Flag follows the lines both ways: any two of channel pin, bandgap, ground
    conflict_flag_a: assert property (@(posedge TCK) disable iff (!RST_N)
        SOURCE_CONFLICT == (((|POS_CHANNEL_SELECT) && (BANDGAP_NEG_SELECT || GROUND_NEG_SELECT))
            || (BANDGAP_NEG_SELECT && GROUND_NEG_SELECT)))
        else $error("negative source conflict flag wrong");
    samp_flag_a: assert property (@(posedge TCK) disable iff (!RST_N)
        (!SAMPLE_HOLD && DAC_WORD != DAC_MIDPOINT) |-> SAMPLE_DAC_ERR)
        else $error("sampling off midpoint not flagged");

    // Dummy conversion: busy eleven cycles, then ready
    sequence dummy_run_s;
        CONVERTER_BUSY [*8] ##1 CONVERTER_BUSY [*3];
    endsequence

    dummy_len_a: assert property (@(posedge CLK) disable iff (!RST_N || !CE || !power_sync)
        $rose(CONVERTER_BUSY) |-> dummy_run_s ##1 (!CONVERTER_BUSY && CONVERTER_READY))
        else $error("dummy conversion length wrong");
    ready_after_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(CONVERTER_READY) |-> $past(CONVERTER_BUSY))
        else $error("ready without dummy conversion");

endmodule : scadc_top

// file: scadc_pkg.sv
/*
 * Shared constants for the converter boundary-scan cells: cell positions in
 * the converter segment of the chain, idle pattern, timing figures, states.
 * Assumes a test controller that sequences capture, shift and update on TCK.
 */
package scadc_pkg;

    // Number of converter cells in the chain segment
    localparam int CHAIN_LEN = 36;

    // Cell positions, bit 0 is the first shifted out
    localparam int POS_SUPPLY_REF = 0;
    localparam int POS_SETTLE = 1;
    localparam int POS_COMPARATOR_PRECHARGE_N_N = 2;
    localparam int POS_PASSGATE = 3;
    localparam int POS_NEG_LO = 4;
    localparam int POS_NEG_HI = 6;
    localparam int POS_CHAN_LO = 7;
    localparam int POS_CHAN_HI = 14;
    localparam int POS_BG_AREF = 15;
    localparam int POS_HOLD = 16;
    localparam int POS_GND_NEG = 17;
    localparam int POS_BYPASS = 18;
    localparam int POS_DAC_LO = 19;
    localparam int POS_DAC_HI = 28;
    localparam int POS_AMP_ON = 29;
    localparam int POS_CONV_ON = 30;
    localparam int POS_BG_NEG = 31;
    localparam int POS_AMP_PATH = 32;
    localparam int POS_AMP_CLK = 33;
    localparam int POS_COMP = 34;
    localparam int POS_SWITCHCAP_TEST_ROUTE = 35;

    // Field widths
    localparam int DAC_W = 10;
    localparam int CHAN_W = 8;
    localparam int NEG_W = 3;

    // Idle values of the individual fields
    localparam logic [DAC_W-1:0] DAC_MIDPOINT = 10'h200;
    localparam logic [CHAN_W-1:0] CHAN_IDLE = 8'h01;
    localparam logic [NEG_W-1:0] NEG_IDLE = 3'h0;

    // Whole idle pattern, highest cell first
    localparam logic [CHAIN_LEN-1:0] CELLS_IDLE = {1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, DAC_MIDPOINT,
        1'b1, 1'b0, 1'b1, 1'b0, CHAN_IDLE, NEG_IDLE, 1'b1, 1'b1, 1'b0, 1'b0};

    // Dummy conversion after power-on and its settle time
    localparam int DUMMY_CMPS = 10;
    localparam int SETTLE_NS = 200;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;

    // Converter power sequence on the system clock
    typedef enum logic [1:0] {CV_OFF, CV_DUMMY, CV_READY} scadc_conv_e;

endpackage : scadc_pkg

// file: scadc_sync.sv
/*
 * Two-flop level synchroniser with clock enable.
 * Assumes d is a level that stays put for several destination clocks.
 */
module scadc_sync
    import scadc_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // Both stages held as one state word
    typedef struct packed {
        logic [W-1:0] s1; // First stage, read only by the second
        logic [W-1:0] s2; // Second stage, safe to use
    } scadc_sync_s;

    scadc_sync_s sync_ff;
    scadc_sync_s nxt_sync;

    // Next state: shift one stage when enabled
    always_comb begin
        nxt_sync = sync_ff;
        if (ce) begin
            nxt_sync.s1 = d;
            nxt_sync.s2 = sync_ff.s1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign q = sync_ff.s2;

endmodule : scadc_sync

// file: scadc_ctrl_model.sv
/*
 * Test controller model for the converter scan segment: runs the test clock
 * through reset, in free ticks and within frames, and scans rows with capture, shift and update strobes.
 * Assumes the bench connects its outputs to the scan port of the block.
 */
module scadc_ctrl_model
    import scadc_pkg::*;
(
    input wire logic tck,
    input wire logic scan_tdo,
    output logic tck_en,
    output logic scan_tdi,
    output logic scan_capture,
    output logic scan_shift,
    output logic scan_update,
    output logic scan_extest
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock runs through reset so the scan side clears
    initial begin
        {tck_en, scan_tdi, scan_capture, scan_shift, scan_update, scan_extest} = 6'h20;
    end

    // Limit-check row: idle cells, channel 3 one-hot, one negative source
    // Channel pin cells sit outside this segment and stay input, pull-up off
    function automatic logic [CHAIN_LEN-1:0] make_row(logic conv, logic [DAC_W-1:0] dac, logic hold, logic pn);
        logic [CHAIN_LEN-1:0] r;
        r = CELLS_IDLE;
        r[POS_CHAN_HI:POS_CHAN_LO] = 8'h08;
        r[POS_CONV_ON] = conv;
        r[POS_DAC_HI:POS_DAC_LO] = dac;
        r[POS_HOLD] = hold;
        r[POS_COMPARATOR_PRECHARGE_N_N] = pn;
        return r;
    endfunction : make_row

    // Free test clock edges, for reset and settling
    task automatic ticks(input int n);
        tck_en = 1'h1;
        repeat (n) @(posedge tck);
        #2 tck_en = 1'h0;
    endtask : ticks

    // One row: settle, capture, 36 shifts bit 0 first, update, settle
    task automatic scan_row(input logic [CHAIN_LEN-1:0] din, input logic extest, output logic [CHAIN_LEN-1:0] dout);
        // A frame may follow a settle that stopped the clock in this very step
        #1 tck_en = 1'h1;
        scan_extest = extest;
        repeat (3) @(posedge tck);
        #2 scan_capture = 1'h1;
        @(posedge tck);
        #2 scan_capture = 1'h0;
        scan_shift = 1'h1;
        dout[0] = scan_tdo;
        scan_tdi = din[0];
        for (int i = 1; i < CHAIN_LEN; i++) begin
            @(posedge tck);
            #2 dout[i] = scan_tdo;
            scan_tdi = din[i];
        end
        @(posedge tck);
        // Released data line shows the inverse, not a stale copy
        #2 scan_tdi = ~scan_tdi;
        scan_shift = 1'h0;
        scan_update = 1'h1;
        @(posedge tck);
        #2 scan_update = 1'h0;
        ticks(3);
    endtask : scan_row
endmodule : scadc_ctrl_model

// file: scadc_top_tb.sv
/*
 * Self-checking bench for the converter scan cells: idle pattern, the
 * limit-check row procedure, the dummy conversion and the advisory flags.
 * Assumes the controller model drives the scan port and the bench the rest.
 */
module scadc_top_tb import scadc_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

    // Analog input level lies between the two limits
    localparam logic [DAC_W-1:0] VIN_CODE = 10'h133;
    localparam logic [DAC_W-1:0] ROW_DAC [1:11] = '{10'h200, 10'h200, 10'h200, 10'h123, 10'h123, 10'h200,
        10'h200, 10'h200, 10'h143, 10'h143, 10'h200};
    localparam logic [11:1] ROW_HOLD = 11'h7bd;
    localparam logic [11:1] ROW_COMPARATOR_PRECHARGE_N = 11'h5ef;

    logic clk = 1'h0, tck = 1'h0, rst_n = 1'h0, ce = 1'h1, comp_in = 1'h0;
    logic tck_en, tdi, cap, sft, upd, ext, tdo;
    logic [CHAN_W-1:0] chan;
    logic [NEG_W-1:0] neg;
    logic [DAC_W-1:0] dac, held = 10'h0;
    logic passgate, comparator_precharge_n_n, switchcap_test_route, settle, supply, amp_on, conv_on, hold, bg_neg, gnd_neg, bypass, bg_aref;
    logic amp_path, amp_clk, conflict, chan_err, sdac_err, busy, ready;
    logic [CHAIN_LEN-1:0] obs;
    int bad_count = 0, comparisons = 0;

    // Converter lines gathered in cell order, result cell left out
    assign obs = {switchcap_test_route, 1'h0, amp_clk, amp_path, bg_neg, conv_on, amp_on, dac, bypass, gnd_neg, hold,
        bg_aref, chan, neg, passgate, comparator_precharge_n_n, settle, supply};

    // System clock free; test clock stops low while tck_en is low
    always #12.5 clk = ~clk;
    always #15 tck = tck_en & ~tck;

    // Comparator: samples while hold low, decides while precharge low
    always @(posedge tck) begin
        if (hold === 1'h0) held <= VIN_CODE;
        if (comparator_precharge_n_n === 1'h0) comp_in <= #2 conv_on & (dac > held);
    end

    scadc_ctrl_model m (.tck(tck), .scan_tdo(tdo), .tck_en(tck_en), .scan_tdi(tdi), .scan_capture(cap),
        .scan_shift(sft), .scan_update(upd), .scan_extest(ext));

    scadc_top dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .TCK(tck), .SCAN_TDI(tdi), .SCAN_CAPTURE(cap),
        .SCAN_SHIFT(sft), .SCAN_UPDATE(upd), .SCAN_EXTEST(ext), .COMP_IN(comp_in), .SCAN_TDO(tdo),
        .POS_CHANNEL_SELECT(chan), .NEG_INPUT_SELECT(neg), .AMP_PASSGATE_ENABLE(passgate),
        .COMPARATOR_PRECHARGE_N(comparator_precharge_n_n), .SWITCHCAP_TEST_ROUTE(switchcap_test_route), .SETTLE_ASSIST(settle),
        .SUPPLY_REF_SELECT(supply), .AMP_POWER_ON(amp_on), .CONVERTER_POWER_ON(conv_on), .DAC_WORD(dac),
        .SAMPLE_HOLD(hold), .BANDGAP_NEG_SELECT(bg_neg), .GROUND_NEG_SELECT(gnd_neg), .BYPASS_SELECT(bypass),
        .BANDGAP_AREF_SELECT(bg_aref), .AMP_PATH_ENABLE(amp_path), .AMP_CLOCK(amp_clk),
        .SOURCE_CONFLICT(conflict), .CHANNEL_SELECT_ERR(chan_err), .SAMPLE_DAC_ERR(sdac_err),
        .CONVERTER_BUSY(busy), .CONVERTER_READY(ready));

    task automatic check(input logic [CHAIN_LEN-1:0] seen, input logic [CHAIN_LEN-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Lines against a row, result cell masked
    task automatic check_lines(input logic [CHAIN_LEN-1:0] exp);
        exp[POS_COMP] = 1'h0;
        check(obs, exp);
    endtask : check_lines

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic fail_wait;
        bad_count++;
        $display("BAD %0t wait ran out", $time);
        wrap_up();
    endtask : fail_wait

    // Idle levels right after reset, from the rules themselves
    task automatic t_reset_idle;
        check({neg, passgate, comparator_precharge_n_n, switchcap_test_route, supply, hold, conv_on, dac}, {3'h0, 4'hc, 2'h2, 10'h200});
        check({tdo, conflict, chan_err, sdac_err, busy, ready}, 6'h0);
    endtask : t_reset_idle

    // Dummy conversion: frozen while CE low, then 11 busy cycles
    task automatic t_dummy;
        int n;
        repeat (20) @(posedge clk);
        #2 check({busy, ready}, 2'h0);
        ce = 1'h1;
        for (n = 0; busy !== 1'h1; n++) begin
            if (n > 10) fail_wait();
            @(posedge clk);
            #2;
        end
        for (n = 0; busy === 1'h1; n++) begin
            if (n > 40) fail_wait();
            @(posedge clk);
            #2;
        end
        check(n, DUMMY_CMPS + 1);
        check(ready, 1'h1);
    endtask : t_dummy

    // Rows 1..11: sample, hold, limit, precharge, read on the next row
    task automatic t_limit_check;
        logic [CHAIN_LEN-1:0] r, so;
        for (int k = 1; k <= 11; k++) begin
            r = m.make_row(1'h1, ROW_DAC[k], ROW_HOLD[k], ROW_COMPARATOR_PRECHARGE_N[k]);
            if (k == 2) begin
                @(posedge clk);
                #2 ce = 1'h0;
            end
            m.scan_row(r, k > 1, so);
            if (k == 1) check(so, CELLS_IDLE);
            check_lines(k > 1 ? r : CELLS_IDLE);
            if (k == 6 || k == 11) check(so[POS_COMP], k == 11);
            if (k == 2) t_dummy();
        end
    endtask : t_limit_check

    // Power off, then a deliberately bad row, then EXTEST low
    task automatic t_flags;
        logic [CHAIN_LEN-1:0] r, so;
        m.scan_row(CELLS_IDLE, 1'h1, so);
        repeat (5) @(posedge clk);
        #2 check({busy, ready}, 2'h0);
        r = CELLS_IDLE;
        r[POS_CHAN_HI:POS_CHAN_LO] = 8'h03;
        r[POS_NEG_HI:POS_NEG_LO] = 3'h5;
        r[POS_DAC_HI:POS_DAC_LO] = 10'h123;
        {r[POS_GND_NEG], r[POS_HOLD], r[POS_SWITCHCAP_TEST_ROUTE], r[POS_SUPPLY_REF], r[POS_PASSGATE], r[POS_COMPARATOR_PRECHARGE_N_N]} = 6'h2c;
        m.scan_row(r, 1'h1, so);
        check_lines(r);
        check({conflict, chan_err, sdac_err}, 3'h7);
        m.scan_row(r, 1'h0, so);
        check_lines(CELLS_IDLE);
        check({conflict, chan_err, sdac_err}, 3'h0);
    endtask : t_flags

    // Reset for six system clocks, then the scenarios
    initial begin
        repeat (6) @(posedge clk);
        #2 rst_n = 1'h1;
        m.ticks(2);
        t_reset_idle();
        t_limit_check();
        t_flags();
        wrap_up();
    end
endmodule : scadc_top_tb
